// File: inc/mci_pkg.sv
// constants shared by the statistics counter indirect read block
package mci_pkg;
  // ---------------------------------------------------------------
  // register offsets on the byte-wide register port
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h79;
  localparam logic [7:0] OFF_ADDR = 8'h7a;
  localparam logic [7:0] OFF_DATA3 = 8'h80;
  localparam logic [7:0] OFF_DATA2 = 8'h81;
  localparam logic [7:0] OFF_DATA1 = 8'h82;
  localparam logic [7:0] OFF_DATA0 = 8'h83;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_OP_MSB = 4;
  localparam int CTRL_OP_LSB = 2;
  localparam logic [2:0] OP_READ_TABLE = 3'h7;
  localparam int CTRL_AHI_MSB = 1;

  // ---------------------------------------------------------------
  // indirect address map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int PP_PORTS = 3;
  localparam int PP_PER_PORT = 32;
  localparam int PP_NUM = PP_PORTS * PP_PER_PORT;
  localparam int PP_IDX_W = 7;
  localparam logic [ADDR_W-1:0] PP_LIMIT = 10'h060;
  localparam logic [ADDR_W-1:0] PORT2_BASE = 10'h020;
  localparam logic [ADDR_W-1:0] PORT3_BASE = 10'h040;
  localparam logic [ADDR_W-1:0] DROP_FIRST = 10'h100;
  localparam logic [ADDR_W-1:0] DROP_LAST = 10'h105;
  localparam int DROP_NUM = 6;
  localparam int DROP_IDX_W = 3;

  // ---------------------------------------------------------------
  // counter widths and data register layout
  // ---------------------------------------------------------------
  localparam int PP_W = 30;
  localparam int DROP_W = 16;
  localparam int BIT_OVF = 7;
  localparam int BIT_VALID = 6;
  localparam int HI_BITS = 6;

  typedef enum logic [1:0] {
    MCI_IDLE,
    MCI_WAIT,
    MCI_PUBLISH
  } mci_state_e;
endpackage

// File: inc/mci_bank_if.sv
// read request and answer between register front end and counter bank
`timescale 1ns/100ps
`default_nettype none
interface mci_bank_if;
  logic rdReq;
  logic [mci_pkg::ADDR_W-1:0] rdAddr;
  logic rdAck;
  logic [mci_pkg::PP_W-1:0] rdCount;
  logic rdOvf;

  modport front (output rdReq, output rdAddr, input rdAck,
                 input rdCount, input rdOvf);
  modport bank (input rdReq, input rdAddr, output rdAck,
                output rdCount, output rdOvf);
endinterface
`default_nettype wire

// File: src/mci_counter_bank.sv
// statistics counter table: per-port and dropped-packet counters
`timescale 1ns/100ps
`default_nettype none
module mci_counter_bank (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic evtValid,
  input wire logic [mci_pkg::ADDR_W-1:0] evtAddr,
  mci_bank_if.bank statistics_counter_table
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [mci_pkg::PP_W-1:0] ppCount [mci_pkg::PP_NUM];
  logic ppOvf [mci_pkg::PP_NUM];
  logic [mci_pkg::DROP_W-1:0] dropCount [mci_pkg::DROP_NUM];

  // ---------------------------------------------------------------
  // address decode for events and reads
  // ---------------------------------------------------------------
  wire evtPp = evtValid && (evtAddr < mci_pkg::PP_LIMIT);
  wire evtDrop = evtValid && (evtAddr >= mci_pkg::DROP_FIRST)
                 && (evtAddr <= mci_pkg::DROP_LAST);
  wire rdPp = statistics_counter_table.rdReq && (statistics_counter_table.rdAddr < mci_pkg::PP_LIMIT);
  wire rdDrop = statistics_counter_table.rdReq && (statistics_counter_table.rdAddr >= mci_pkg::DROP_FIRST)
                && (statistics_counter_table.rdAddr <= mci_pkg::DROP_LAST);
  // port base plus offset is the flat index, bases are 32 apart
  wire [mci_pkg::PP_IDX_W-1:0] evtPpIdx =
    evtAddr[mci_pkg::PP_IDX_W-1:0];
  wire [mci_pkg::PP_IDX_W-1:0] rdPpIdx =
    statistics_counter_table.rdAddr[mci_pkg::PP_IDX_W-1:0];
  wire [mci_pkg::ADDR_W-1:0] evtDropOff = evtAddr - mci_pkg::DROP_FIRST;
  wire [mci_pkg::ADDR_W-1:0] rdDropOff =
    statistics_counter_table.rdAddr - mci_pkg::DROP_FIRST;
  wire [mci_pkg::DROP_IDX_W-1:0] evtDropIdx =
    evtDropOff[mci_pkg::DROP_IDX_W-1:0];
  wire [mci_pkg::DROP_IDX_W-1:0] rdDropIdx =
    rdDropOff[mci_pkg::DROP_IDX_W-1:0];
  wire sameSlot = evtPp && rdPp && (evtPpIdx == rdPpIdx);
  wire [mci_pkg::PP_W:0] ppSum = {1'b0, ppCount[evtPpIdx]} + 31'h1;
  wire [mci_pkg::PP_W-1:0] clearValue =
    sameSlot ? mci_pkg::PP_W'(1) : '0;

  // ---------------------------------------------------------------
  // counting and read with clear; later assignments win
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < mci_pkg::PP_NUM; i++) begin
        ppCount[i] <= '0;
        ppOvf[i] <= 1'b0;
      end
      for (int j = 0; j < mci_pkg::DROP_NUM; j++) begin
        dropCount[j] <= '0;
      end
      statistics_counter_table.rdAck <= 1'b0;
      statistics_counter_table.rdCount <= '0;
      statistics_counter_table.rdOvf <= 1'b0;
    end else begin
      statistics_counter_table.rdAck <= statistics_counter_table.rdReq;
      if (evtPp) begin
        ppCount[evtPpIdx] <= ppSum[mci_pkg::PP_W-1:0];
        if (ppSum[mci_pkg::PP_W])
          ppOvf[evtPpIdx] <= 1'b1;
      end
      if (evtDrop) begin
        dropCount[evtDropIdx] <= dropCount[evtDropIdx] + 16'h1;
      end
      if (rdPp) begin
        statistics_counter_table.rdCount <= ppCount[rdPpIdx];
        statistics_counter_table.rdOvf <= ppOvf[rdPpIdx];
        // an event in the clearing cycle survives as a count of one
        ppCount[rdPpIdx] <= clearValue;
        // a wrap in the clearing cycle keeps its flag: the set wins
        ppOvf[rdPpIdx] <= sameSlot && ppSum[mci_pkg::PP_W];
      end else if (rdDrop) begin
        statistics_counter_table.rdCount <= {14'h0, dropCount[rdDropIdx]};
        statistics_counter_table.rdOvf <= 1'b0;
      end else if (statistics_counter_table.rdReq) begin
        statistics_counter_table.rdCount <= '0;
        statistics_counter_table.rdOvf <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_clearOnRead;
    @(posedge clk_sys) disable iff (sys_rst)
    rdPp && !sameSlot |=> ppCount[$past(rdPpIdx)] == '0;
  endproperty
  a_clearOnRead: assert property (p_clearOnRead)
    else $error("per-port counter not cleared by read");

  property p_dropKeep;
    @(posedge clk_sys) disable iff (sys_rst)
    rdDrop && !evtDrop |=>
      dropCount[$past(rdDropIdx)] == $past(dropCount[rdDropIdx])
      && statistics_counter_table.rdAck;
  endproperty
  a_dropKeep: assert property (p_dropKeep)
    else $error("dropped-packet counter changed by read");
endmodule
`default_nettype wire

// File: src/mci_counter_indirect_read.sv
// indirect read front end for the statistics counter table
//
// What this block does
// - Writing the address register starts the indirect counter read when the control op field holds OP_READ_TABLE.
// - A per-port counter address is the port base plus the offset.
// - Bit 31 of the first data register shows per-port overflow.
// - Bit 30 is the valid flag; while zero the host rereads from there.
// - The 30-bit count spreads 6 bits plus three bytes, high first.
// - Low byte 0x00 in the upper range reads port one transmit drops.
// - Dropped-packet counts return in the last two data registers.
// - A per-port counter clears once an indirect read returns it.
// - Dropped-packet counters are not altered by reads.
// - Dropped-packet reads carry no overflow or valid flag.
// - Ports own 32-entry ranges starting at 0x00, 0x20 and 0x40.
// - Dropped-packet counters sit at indirect 0x100 to 0x105.
`timescale 1ns/100ps
`default_nettype none
module mci_counter_indirect_read (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic evtValid,
  input wire logic [mci_pkg::ADDR_W-1:0] evtAddr,
  output logic readBusy
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mci_bank_if statistics_counter_table ();
  mci_pkg::mci_state_e state;
  mci_pkg::mci_state_e next_state;
  logic [7:0] ctrlReg;
  logic [7:0] addrLow;
  logic isDrop;
  logic valid;
  logic ovfBit;
  logic [mci_pkg::HI_BITS-1:0] dataHi;
  logic [7:0] data2;
  logic [7:0] data1;
  logic [7:0] data0;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire wrCtrl = regWrEn && (regAddr == mci_pkg::OFF_CTRL);
  wire wrAddr = regWrEn && (regAddr == mci_pkg::OFF_ADDR);
  wire tableSel = ctrlReg[mci_pkg::CTRL_OP_MSB:mci_pkg::CTRL_OP_LSB]
                  == mci_pkg::OP_READ_TABLE;
  // a trigger while a read is in flight is ignored, never queued
  wire trigger = wrAddr && tableSel && (state == mci_pkg::MCI_IDLE);
  wire [mci_pkg::ADDR_W-1:0] fullAddr =
    {ctrlReg[mci_pkg::CTRL_AHI_MSB:0], regWdata};
  wire addrIsDrop = fullAddr[mci_pkg::ADDR_W-1:8] != 2'h0;
  wire [7:0] data3 = isDrop ? 8'h00 : {ovfBit, valid, dataHi};
  wire [7:0] readMux =
    (regAddr == mci_pkg::OFF_CTRL) ? ctrlReg :
    (regAddr == mci_pkg::OFF_ADDR) ? addrLow :
    (regAddr == mci_pkg::OFF_DATA3) ? data3 :
    (regAddr == mci_pkg::OFF_DATA2) ? data2 :
    (regAddr == mci_pkg::OFF_DATA1) ? data1 :
    (regAddr == mci_pkg::OFF_DATA0) ? data0 :
    mci_pkg::UNMAPPED_READ;

  assign readBusy = state != mci_pkg::MCI_IDLE;

  // ---------------------------------------------------------------
  // sequencer: request, wait for the snapshot, then publish valid
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      mci_pkg::MCI_IDLE: begin
        if (trigger)
          next_state = mci_pkg::MCI_WAIT;
      end
      mci_pkg::MCI_WAIT: begin
        if (statistics_counter_table.rdAck)
          next_state = mci_pkg::MCI_PUBLISH;
      end
      default: begin
        next_state = mci_pkg::MCI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      state <= mci_pkg::MCI_IDLE;
    else
      state <= next_state;
  end

  // host writable registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlReg <= mci_pkg::CTRL_RESET;
      addrLow <= mci_pkg::ADDR_RESET;
    end else begin
      if (wrCtrl)
        ctrlReg <= regWdata;
      if (wrAddr)
        addrLow <= regWdata;
    end
  end

  // one-cycle request to the bank, launched by the address write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      statistics_counter_table.rdReq <= 1'b0;
      statistics_counter_table.rdAddr <= '0;
      isDrop <= 1'b0;
    end else begin
      statistics_counter_table.rdReq <= trigger;
      if (trigger) begin
        statistics_counter_table.rdAddr <= fullAddr;
        isDrop <= addrIsDrop;
      end
    end
  end

  // snapshot lands in all data registers in one edge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ovfBit <= 1'b0;
      dataHi <= '0;
      data2 <= 8'h00;
      data1 <= 8'h00;
      data0 <= 8'h00;
    end else if (statistics_counter_table.rdAck) begin
      ovfBit <= statistics_counter_table.rdOvf;
      {dataHi, data2, data1, data0} <= statistics_counter_table.rdCount;
    end
  end

  // valid drops on a new trigger and rises a cycle after the load
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      valid <= 1'b0;
    else if (trigger)
      valid <= 1'b0;
    else if (state == mci_pkg::MCI_PUBLISH)
      valid <= 1'b1;
  end

  // read data is registered so the port sees a flop output
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      regRdata <= 8'h00;
    else if (regRdEn)
      regRdata <= readMux;
  end

  mci_counter_bank u_bank (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .evtValid(evtValid),
    .evtAddr(evtAddr),
    .statistics_counter_table(statistics_counter_table.bank)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_trig;
    trigger;
  endsequence

  sequence s_fetch;
    statistics_counter_table.rdReq && !valid ##1 statistics_counter_table.rdAck && !valid;
  endsequence

  property p_trigStart;
    @(posedge clk_sys) disable iff (sys_rst)
    s_trig |=> s_fetch ##1 !valid ##1 valid;
  endproperty
  a_trigStart: assert property (p_trigStart)
    else $error("trigger did not run request then publish");

  property p_noTrigNoReq;
    @(posedge clk_sys) disable iff (sys_rst)
    wrAddr && !tableSel |=> !statistics_counter_table.rdReq;
  endproperty
  a_noTrigNoReq: assert property (p_noTrigNoReq)
    else $error("read started without table select code");

  property p_ovfBit;
    @(posedge clk_sys) disable iff (sys_rst)
    statistics_counter_table.rdAck && !isDrop |=> data3[mci_pkg::BIT_OVF] == $past(statistics_counter_table.rdOvf);
  endproperty
  a_ovfBit: assert property (p_ovfBit)
    else $error("overflow bit does not follow counter");

  property p_validBit;
    @(posedge clk_sys) disable iff (sys_rst)
    // the host must never see valid while a read is still in flight
    !isDrop |-> data3[mci_pkg::BIT_VALID] == (valid && !readBusy);
  endproperty
  a_validBit: assert property (p_validBit)
    else $error("valid bit missing from first data register");

  property p_ppBytes;
    @(posedge clk_sys) disable iff (sys_rst)
    statistics_counter_table.rdAck && !isDrop |=>
      {dataHi, data2, data1, data0} == $past(statistics_counter_table.rdCount);
  endproperty
  a_ppBytes: assert property (p_ppBytes)
    else $error("per-port bytes out of order");

  property p_dropBytes;
    @(posedge clk_sys) disable iff (sys_rst)
    statistics_counter_table.rdAck && isDrop |=> data3 == 8'h00 && data2 == 8'h00
      && {data1, data0} == $past(statistics_counter_table.rdCount[mci_pkg::DROP_W-1:0]);
  endproperty
  a_dropBytes: assert property (p_dropBytes)
    else $error("dropped-packet bytes misplaced");

  property p_dropAddr;
    @(posedge clk_sys) disable iff (sys_rst)
    trigger && ctrlReg[0] |=> statistics_counter_table.rdAddr == $past(fullAddr)
      && statistics_counter_table.rdAddr >= mci_pkg::DROP_FIRST && isDrop;
  endproperty
  a_dropAddr: assert property (p_dropAddr)
    else $error("upper range address not formed");

  property p_portBase;
    @(posedge clk_sys) disable iff (sys_rst)
    trigger && !ctrlReg[0] && !ctrlReg[1] |=>
      statistics_counter_table.rdAddr == {2'h0, $past(regWdata)} && !isDrop;
  endproperty
  a_portBase: assert property (p_portBase)
    else $error("per-port address not base plus offset");
endmodule
`default_nettype wire

// File: sim/mci_host_model.sv
// host processor model driving the byte-wide register port
`timescale 1ns/100ps
`default_nettype none
module mci_host_model (
  input wire logic clk_sys,
  output var logic regWrEn,
  output var logic regRdEn,
  output var logic [7:0] regAddr,
  output var logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic readBusy
);
  // ---------------------------------------------------------------
  // register port cycles
  // ---------------------------------------------------------------
  // port idle at time zero
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end

  // one strobe edge, then scramble idle lines so stale values never help
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    regWrEn <= 1'b1;
    regAddr <= addr;
    regWdata <= data;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    regAddr <= ~addr;
    regWdata <= ~data;
  endtask

  // read data is registered, so it is taken a full cycle later
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    regRdEn <= 1'b1;
    regAddr <= addr;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    regAddr <= ~addr;
    @(posedge clk_sys);
    @(negedge clk_sys);
    data = regRdata;
  endtask

  // ---------------------------------------------------------------
  // indirect counter fetch, done on demand well inside the refresh span
  // ---------------------------------------------------------------
  task automatic fetch(input logic [7:0] ctrl, input logic [7:0] lo,
                       input logic perPort, output logic [31:0] got,
                       output logic busySeen);
    int n;
    wr(mci_pkg::OFF_CTRL, ctrl);
    wr(mci_pkg::OFF_ADDR, lo);
    @(negedge clk_sys);
    busySeen = readBusy;
    n = 0;
    // drop reads carry no valid flag, so the busy line paces them
    while (!perPort && readBusy !== 1'b0 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    // reread the flag register until valid shows
    do begin
      rd(mci_pkg::OFF_DATA3, got[31:24]);
      n++;
    end while (perPort && got[30] !== 1'b1 && n < 20);
    rd(mci_pkg::OFF_DATA2, got[23:16]);
    rd(mci_pkg::OFF_DATA1, got[15:8]);
    rd(mci_pkg::OFF_DATA0, got[7:0]);
  endtask
endmodule
`default_nettype wire

// File: sim/tb_mci_counter_indirect_read.sv
// self-checking testbench for the statistics counter indirect read block
`timescale 1ns/100ps
`default_nettype none
module tb_mci_counter_indirect_read;
  logic clk_sys;
  logic sys_rst;
  logic regWrEn;
  logic regRdEn;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic evtValid;
  logic [mci_pkg::ADDR_W-1:0] evtAddr;
  logic readBusy;
  logic [31:0] got;
  logic busy;
  logic [7:0] b;
  logic [7:0] offs [6];
  int num_errors;
  int num_checks;

  // ---------------------------------------------------------------
  // design and host
  // ---------------------------------------------------------------
  mci_counter_indirect_read i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .evtValid(evtValid),
    .evtAddr(evtAddr), .readBusy(readBusy));
  mci_host_model i_host (.clk_sys(clk_sys), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .readBusy(readBusy));

  // 10 MHz clock
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // compare and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // n counting events on one slot, one per edge
  task automatic bump(input logic [9:0] a, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      evtValid <= 1'b1;
      evtAddr <= a;
    end
    @(posedge clk_sys);
    evtValid <= 1'b0;
  endtask

  // full indirect read with the busy line checked right after trigger
  task automatic run_read(input logic [7:0] ctrl, input logic [7:0] lo,
                          input logic perPort, input logic [31:0] exp);
    i_host.fetch(ctrl, lo, perPort, got, busy);
    check("busy", {31'h0, busy}, 32'h1);
    check("count", got, exp);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    evtValid = 1'b0;
    evtAddr = '0;
    num_errors = 0;
    num_checks = 0;
    offs = '{8'h79, 8'h7a, 8'h80, 8'h81, 8'h82, 8'h83};
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // every register starts at zero
    for (int i = 0; i < 6; i++) begin
      i_host.rd(offs[i], b);
      check("reset value", {24'h0, b}, 32'h0);
    end
    // writable registers read back, unmapped place reads the idle value
    i_host.wr(mci_pkg::OFF_CTRL, 8'h1d);
    i_host.rd(mci_pkg::OFF_CTRL, b);
    check("ctrl", {24'h0, b}, 32'h1d);
    i_host.wr(mci_pkg::OFF_ADDR, 8'h5a);
    i_host.rd(mci_pkg::OFF_ADDR, b);
    check("addr", {24'h0, b}, 32'h5a);
    i_host.rd(8'h55, b);
    check("unmapped", {24'h0, b}, {24'h0, mci_pkg::UNMAPPED_READ});
    // second port slot, then cleared by that read
    bump(10'h02e, 5);
    run_read(8'h1c, 8'h2e, 1'b1, 32'h4000_0005);
    run_read(8'h1c, 8'h2e, 1'b1, 32'h4000_0000);
    // a count spanning two bytes lands high byte first
    bump(10'h005, 291);
    run_read(8'h1c, 8'h05, 1'b1, 32'h4000_0123);
    bump(10'h05f, 2);
    run_read(8'h1c, 8'h5f, 1'b1, 32'h4000_0002);
    // dropped-packet counters: no flags, kept across reads
    bump(10'h100, 421);
    run_read(8'h1d, 8'h00, 1'b0, 32'h0000_01a5);
    run_read(8'h1d, 8'h00, 1'b0, 32'h0000_01a5);
    bump(10'h105, 3);
    run_read(8'h1d, 8'h05, 1'b0, 32'h0000_0003);
    // wrong control code: the address write starts nothing, nothing clears
    bump(10'h02e, 1);
    i_host.wr(mci_pkg::OFF_CTRL, 8'h00);
    i_host.wr(mci_pkg::OFF_ADDR, 8'h2e);
    @(negedge clk_sys);
    check("refused busy", {31'h0, readBusy}, 32'h0);
    run_read(8'h1c, 8'h2e, 1'b1, 32'h4000_0001);
    // data registers ignore writes
    i_host.wr(mci_pkg::OFF_DATA0, 8'hff);
    i_host.rd(mci_pkg::OFF_DATA0, b);
    check("data write ignored", {24'h0, b}, 32'h01);
    give_verdict();
  end

  // watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    #2000000;
    num_errors++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
`default_nettype wire
